// file: pkg/bec_params.svh
// Register offsets, field positions and reset values of the bus event comparator
`ifndef BEC_PARAMS_SVH
`define BEC_PARAMS_SVH

// Register byte offsets (low eight address bits)
`define BEC_OFF_CTRL     8'h00
`define BEC_OFF_ADDR_LO  8'h04
`define BEC_OFF_ADDR_HI  8'h08
`define BEC_OFF_DVAL     8'h0C
`define BEC_OFF_DMASK    8'h10
`define BEC_OFF_SSEL     8'h14
`define BEC_OFF_ASEL     8'h18
`define BEC_OFF_ISTS     8'h1C
`define BEC_OFF_IMSK     8'h20
`define BEC_OFF_HCNT     8'h24
`define BEC_OFF_HADDR    8'h28

// Control register fields
`define BEC_CTRL_W       12
`define BEC_CTRL_EN      0
`define BEC_CTRL_SWB     1
`define BEC_CTRL_AM_LO   2
`define BEC_CTRL_AM_HI   3
`define BEC_CTRL_NEG     4
`define BEC_CTRL_DEN     5
`define BEC_CTRL_MEN     6
`define BEC_CTRL_WORD    7
`define BEC_CTRL_DIR_LO  8
`define BEC_CTRL_DIR_HI  9
`define BEC_CTRL_SIGN    10
`define BEC_CTRL_AIGN    11

// Interrupt status bit
`define BEC_IRQ_HIT      0

// Reset values
`define BEC_CTRL_RST     12'h0E00
`define BEC_SEL_RST      8'hFF
`define BEC_WORD_RST     32'h0000_0000

`endif

// file: pkg/bec_pkg.sv
// Types shared by the bus event comparator modules
package bec_pkg;

    // Address condition kinds
    typedef enum logic [1:0] {
        BEC_AM_IGNORE,
        BEC_AM_SINGLE,
        BEC_AM_RANGE
    } bec_addr_mode_t;

    // Direction condition kinds
    typedef enum logic [1:0] {
        BEC_DIR_READ,
        BEC_DIR_WRITE,
        BEC_DIR_EITHER
    } bec_dir_t;

endpackage : bec_pkg

// file: pkg/bec_cfg_if.sv
// Configuration and hit carrier between register file and comparator
`timescale 1ns/1ns
interface bec_cfg_if
    import bec_pkg::*;
#(
    parameter int AW = 24,
    parameter int DW = 16,
    parameter int SW = 3,
    parameter int RW = 3
);
    logic              sw_break;
    bec_addr_mode_t    addr_mode;
    logic              negate;
    logic              data_en;
    logic              mask_en;
    logic              word_sel;
    bec_dir_t          dir;
    logic              state_ign;
    logic              area_ign;
    logic [AW-1:0]     addr_lo;
    logic [AW-1:0]     addr_hi;
    logic [DW-1:0]     data_val;
    logic [DW-1:0]     data_mask;
    logic [2**SW-1:0]  state_sel;
    logic [2**RW-1:0]  area_sel;
    logic              hit;

    // Register side drives the settings
    modport ctl (
        output sw_break, addr_mode, negate, data_en, mask_en, word_sel, dir,
        output state_ign, area_ign, addr_lo, addr_hi, data_val, data_mask,
        output state_sel, area_sel,
        input  hit
    );

    // Comparator side reads them
    modport mt (
        input  sw_break, addr_mode, negate, data_en, mask_en, word_sel, dir,
        input  state_ign, area_ign, addr_lo, addr_hi, data_val, data_mask,
        input  state_sel, area_sel,
        output hit
    );
endinterface : bec_cfg_if

// file: core/bec_match.sv
// Combinational condition comparator for one monitored bus cycle
`timescale 1ns/1ns
module bec_match
    import bec_pkg::*;
#(
    parameter int AW = 24,
    parameter int DW = 16,
    parameter int SW = 3,
    parameter int RW = 3
)
(
    // Clock and reset, used by the checks only
    input  wire logic          clock,
    input  wire logic          reset,
    // Settings and hit
    bec_cfg_if.mt              cfg,
    // Monitored bus cycle
    input  wire logic          mon_valid,
    input  wire logic [AW-1:0] mon_addr,
    input  wire logic [DW-1:0] mon_data,
    input  wire logic          mon_word,
    input  wire logic          mon_write,
    input  wire logic          mon_fetch,
    input  wire logic [SW-1:0] mon_state,
    input  wire logic [RW-1:0] mon_area
);
    logic          addr_eq;
    logic          addr_in;
    logic          addr_raw;
    logic          addr_ok;
    logic [DW-1:0] dmask;
    logic          dval_ok;
    logic          dsz_ok;
    logic          data_ok;
    logic          dir_ok;
    logic          state_ok;
    logic          area_ok;

    // Address window; range bounds are inclusive
    always_comb
    begin
        addr_eq = (mon_addr == cfg.addr_lo);
        addr_in = (mon_addr >= cfg.addr_lo) && (mon_addr <= cfg.addr_hi);
        case (cfg.addr_mode)
            BEC_AM_IGNORE: addr_raw = 1'b1;
            BEC_AM_SINGLE: addr_raw = addr_eq;
            BEC_AM_RANGE:  addr_raw = addr_in;
            default:       addr_raw = 1'b0;
        endcase
        if (cfg.addr_mode == BEC_AM_IGNORE)
            addr_ok = 1'b1;
        else
            addr_ok = addr_raw ^ cfg.negate;
    end

    // Data condition; a byte access compares the low lane only
    always_comb
    begin
        dmask = cfg.mask_en ? cfg.data_mask : {DW{1'b1}};
        if (!cfg.word_sel)
            dmask = dmask & {{(DW-8){1'b0}}, 8'hFF};
        dval_ok = ((mon_data & dmask) == (cfg.data_val & dmask));
        dsz_ok  = (mon_word == cfg.word_sel);
        data_ok = !cfg.data_en || (dval_ok && dsz_ok);
    end

    // Direction, bus state and area
    always_comb
    begin
        case (cfg.dir)
            BEC_DIR_READ:   dir_ok = !mon_write;
            BEC_DIR_WRITE:  dir_ok = mon_write;
            BEC_DIR_EITHER: dir_ok = 1'b1;
            default:        dir_ok = 1'b0;
        endcase
        state_ok = cfg.state_ign || cfg.state_sel[mon_state];
        area_ok  = cfg.area_ign || cfg.area_sel[mon_area];
    end

    // Software break overrides every other setting
    assign cfg.hit = mon_valid && (cfg.sw_break ? (mon_fetch && addr_eq)
                   : (addr_ok && data_ok && dir_ok && state_ok && area_ok));

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    AST_SWB_ONLY_FETCH: assert property (
        cfg.sw_break && cfg.hit |-> mon_fetch && (mon_addr == cfg.addr_lo))
        else $error("software break hit without fetch at the low address");
    AST_ADDR_IGNORE: assert property (
        !cfg.sw_break && cfg.addr_mode == BEC_AM_IGNORE |-> addr_ok)
        else $error("ignored address not satisfied");
    AST_SINGLE_EQ: assert property (
        cfg.addr_mode == BEC_AM_SINGLE && !cfg.negate |-> addr_ok == addr_eq)
        else $error("single address match wrong");
    AST_RANGE_IN: assert property (
        cfg.addr_mode == BEC_AM_RANGE && !cfg.negate
        |-> addr_ok == ((mon_addr >= cfg.addr_lo) && (mon_addr <= cfg.addr_hi)))
        else $error("range match wrong");
    AST_NEGATE: assert property (
        cfg.addr_mode == BEC_AM_RANGE && cfg.negate && addr_ok
        |-> (mon_addr < cfg.addr_lo) || (mon_addr > cfg.addr_hi))
        else $error("negated range accepted an inside address");
    AST_DATA_OFF: assert property (
        !cfg.data_en |-> data_ok)
        else $error("disabled data compare blocked the event");
    AST_MASKED_EQ: assert property (
        cfg.data_en && cfg.mask_en && cfg.word_sel && mon_word && data_ok
        |-> (mon_data & cfg.data_mask) == (cfg.data_val & cfg.data_mask))
        else $error("masked data compare wrong");
    AST_SIZE: assert property (
        cfg.data_en && data_ok |-> mon_word == cfg.word_sel)
        else $error("access size mismatch accepted");
    AST_DIR: assert property (
        !cfg.sw_break && cfg.hit |-> (cfg.dir == BEC_DIR_EITHER)
        || (mon_write == (cfg.dir == BEC_DIR_WRITE)))
        else $error("direction condition violated");
    AST_STATE_AREA: assert property (
        !cfg.sw_break && cfg.hit |-> (cfg.state_ign || cfg.state_sel[mon_state])
        && (cfg.area_ign || cfg.area_sel[mon_area]))
        else $error("bus state or area condition violated");
    AST_IGN_ANY: assert property (
        cfg.state_ign && cfg.area_ign |-> state_ok && area_ok)
        else $error("ignored state or area not satisfied");
endmodule : bec_match

// file: core/bec_top.sv
// Bus event comparator with Wishbone register file and hit interrupt
//
// How it works
// - Software break matches only a fetch at exactly the low address, ignoring all else.
// - An ignored address condition is met by every bus cycle.
// - Single-address mode matches only when the bus address equals the low address.
// - Range mode matches an address from the low address up to the high address.
// - Negation with single or range mode inverts the address match.
// - Data takes part only when data compare is on; otherwise it is always met.
// - With masking, bus data and compare value are both ANDed with the mask, then compared.
// - With data compare on, the cycle's access size must equal the chosen byte or word.
// - Direction accepts reads only, writes only, or either, as selected.
// - Events are also qualified by the cycle's bus state and memory area.
// - An ignored bus state or area condition accepts any state or area.
//
// Implementation choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ns
`include "bec_params.svh"
module bec_top
    import bec_pkg::*;
#(
    parameter int AW = 24,
    parameter int DW = 16,
    parameter int SW = 3,
    parameter int RW = 3
)
(
    // Clock and reset
    input  wire logic          clock,
    input  wire logic          reset,
    // Wishbone classic slave
    input  wire logic          wb_cyc_i,
    input  wire logic          wb_stb_i,
    input  wire logic          wb_we_i,
    input  wire logic [7:0]    wb_adr_i,
    input  wire logic [3:0]    wb_sel_i,
    input  wire logic [31:0]   wb_dat_i,
    output logic      [31:0]   wb_dat_o,
    output logic               wb_ack_o,
    // Monitored target bus cycle
    input  wire logic          mon_valid,
    input  wire logic [AW-1:0] mon_addr,
    input  wire logic [DW-1:0] mon_data,
    input  wire logic          mon_word,
    input  wire logic          mon_write,
    input  wire logic          mon_fetch,
    input  wire logic [SW-1:0] mon_state,
    input  wire logic [RW-1:0] mon_area,
    // Event outputs
    output logic               event_hit,
    output logic               irq
);
    localparam int SN = 2**SW;
    localparam int RN = 2**RW;

    logic [`BEC_CTRL_W-1:0] ctrl_q, ctrl_d;
    logic [AW-1:0]          lo_q, lo_d;
    logic [AW-1:0]          hi_q, hi_d;
    logic [DW-1:0]          val_q, val_d;
    logic [DW-1:0]          msk_q, msk_d;
    logic [SN-1:0]          ssel_q, ssel_d;
    logic [RN-1:0]          asel_q, asel_d;
    logic                   ists_q, ists_d;
    logic                   imsk_q, imsk_d;
    logic [31:0]            cnt_q, cnt_d;
    logic [AW-1:0]          last_q, last_d;
    logic                   ack_q, ack_d;
    logic [31:0]            dat_q, dat_d;
    logic                   hit_q, hit_d;
    logic                   irq_q, irq_d;
    logic                   access;
    logic                   wr;
    logic                   hit_now;
    logic [31:0]            be;
    logic [31:0]            rd_val;
    logic [31:0]            merged;

    bec_cfg_if #(.AW(AW), .DW(DW), .SW(SW), .RW(RW)) cfg ();

    // Settings fan out from the control word and the other setting registers
    assign cfg.sw_break  = ctrl_q[`BEC_CTRL_SWB];
    assign cfg.addr_mode = bec_addr_mode_t'(ctrl_q[`BEC_CTRL_AM_HI:`BEC_CTRL_AM_LO]);
    assign cfg.negate    = ctrl_q[`BEC_CTRL_NEG];
    assign cfg.data_en   = ctrl_q[`BEC_CTRL_DEN];
    assign cfg.mask_en   = ctrl_q[`BEC_CTRL_MEN];
    assign cfg.word_sel  = ctrl_q[`BEC_CTRL_WORD];
    assign cfg.dir       = bec_dir_t'(ctrl_q[`BEC_CTRL_DIR_HI:`BEC_CTRL_DIR_LO]);
    assign cfg.state_ign = ctrl_q[`BEC_CTRL_SIGN];
    assign cfg.area_ign  = ctrl_q[`BEC_CTRL_AIGN];
    assign cfg.addr_lo   = lo_q;
    assign cfg.addr_hi   = hi_q;
    assign cfg.data_val  = val_q;
    assign cfg.data_mask = msk_q;
    assign cfg.state_sel = ssel_q;
    assign cfg.area_sel  = asel_q;

    // Condition comparator
    bec_match #(.AW(AW), .DW(DW), .SW(SW), .RW(RW)) u_match (
        .clock     (clock),
        .reset     (reset),
        .cfg       (cfg),
        .mon_valid (mon_valid),
        .mon_addr  (mon_addr),
        .mon_data  (mon_data),
        .mon_word  (mon_word),
        .mon_write (mon_write),
        .mon_fetch (mon_fetch),
        .mon_state (mon_state),
        .mon_area  (mon_area)
    );

    // One access per request; ack_q blocks a second take in the ack cycle
    assign access  = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr      = access && wb_we_i;
    assign hit_now = cfg.hit && ctrl_q[`BEC_CTRL_EN];

    // Byte lanes from the select lines
    always_comb
    begin
        be = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    end

    // Read mux; unmapped offsets read as zero
    always_comb
    begin
        case (wb_adr_i)
            `BEC_OFF_CTRL:    rd_val = 32'(ctrl_q);
            `BEC_OFF_ADDR_LO: rd_val = 32'(lo_q);
            `BEC_OFF_ADDR_HI: rd_val = 32'(hi_q);
            `BEC_OFF_DVAL:    rd_val = 32'(val_q);
            `BEC_OFF_DMASK:   rd_val = 32'(msk_q);
            `BEC_OFF_SSEL:    rd_val = 32'(ssel_q);
            `BEC_OFF_ASEL:    rd_val = 32'(asel_q);
            `BEC_OFF_ISTS:    rd_val = 32'(ists_q);
            `BEC_OFF_IMSK:    rd_val = 32'(imsk_q);
            `BEC_OFF_HCNT:    rd_val = cnt_q;
            `BEC_OFF_HADDR:   rd_val = 32'(last_q);
            default:          rd_val = `BEC_WORD_RST;
        endcase
        merged = (rd_val & ~be) | (wb_dat_i & be);
    end

    // Next state of registers, bus answer and event outputs
    always_comb
    begin
        ctrl_d = ctrl_q;
        lo_d   = lo_q;
        hi_d   = hi_q;
        val_d  = val_q;
        msk_d  = msk_q;
        ssel_d = ssel_q;
        asel_d = asel_q;
        imsk_d = imsk_q;
        cnt_d  = cnt_q;
        last_d = last_q;
        ack_d  = access;
        dat_d  = access ? rd_val : dat_q;
        if (wr)
        begin
            case (wb_adr_i)
                `BEC_OFF_CTRL:    ctrl_d = merged[`BEC_CTRL_W-1:0];
                `BEC_OFF_ADDR_LO: lo_d   = merged[AW-1:0];
                `BEC_OFF_ADDR_HI: hi_d   = merged[AW-1:0];
                `BEC_OFF_DVAL:    val_d  = merged[DW-1:0];
                `BEC_OFF_DMASK:   msk_d  = merged[DW-1:0];
                `BEC_OFF_SSEL:    ssel_d = merged[SN-1:0];
                `BEC_OFF_ASEL:    asel_d = merged[RN-1:0];
                `BEC_OFF_IMSK:    imsk_d = merged[`BEC_IRQ_HIT];
                default:          ctrl_d = ctrl_q;
            endcase
        end
        // Count wraps; software reads the difference between two samples
        if (hit_now)
        begin
            cnt_d  = cnt_q + 32'h0000_0001;
            last_d = mon_addr;
        end
        // New hit wins over a write-one clear in the same cycle
        ists_d = (ists_q && !(wr && wb_adr_i == `BEC_OFF_ISTS && merged[`BEC_IRQ_HIT]))
                 || hit_now;
        hit_d  = hit_now;
        irq_d  = ists_d && imsk_d;
    end

    // Register stage
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            ctrl_q <= `BEC_CTRL_RST;
            lo_q   <= '0;
            hi_q   <= '0;
            val_q  <= '0;
            msk_q  <= '0;
            ssel_q <= {SN{1'b1}};
            asel_q <= {RN{1'b1}};
            ists_q <= 1'b0;
            imsk_q <= 1'b0;
            cnt_q  <= `BEC_WORD_RST;
            last_q <= '0;
            ack_q  <= 1'b0;
            dat_q  <= `BEC_WORD_RST;
            hit_q  <= 1'b0;
            irq_q  <= 1'b0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            lo_q   <= lo_d;
            hi_q   <= hi_d;
            val_q  <= val_d;
            msk_q  <= msk_d;
            ssel_q <= ssel_d;
            asel_q <= asel_d;
            ists_q <= ists_d;
            imsk_q <= imsk_d;
            cnt_q  <= cnt_d;
            last_q <= last_d;
            ack_q  <= ack_d;
            dat_q  <= dat_d;
            hit_q  <= hit_d;
            irq_q  <= irq_d;
        end
    end

    // Outputs straight from flops
    assign wb_ack_o  = ack_q;
    assign wb_dat_o  = dat_q;
    assign event_hit = hit_q;
    assign irq       = irq_q;

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    AST_HIT_ALL_MET: assert property (
        event_hit |-> $past(ctrl_q[`BEC_CTRL_EN]) && $past(mon_valid))
        else $error("hit without an enabled valid cycle");
    AST_HIT_FOLLOWS: assert property (
        ctrl_q[`BEC_CTRL_EN] && cfg.hit |=> event_hit && ists_q)
        else $error("hit not reported in the next cycle");
    AST_SWB_HIT: assert property (
        ctrl_q[`BEC_CTRL_EN] && cfg.sw_break && mon_valid && mon_fetch
        && mon_addr == lo_q |=> event_hit && last_q == $past(mon_addr))
        else $error("software break fetch missed");
    AST_ACK_ONE: assert property (
        wb_cyc_i && wb_stb_i && !ack_q |=> ack_q ##1 !ack_q)
        else $error("ack not a single cycle");
    AST_IRQ_LEVEL: assert property (
        irq |-> ists_q && imsk_q)
        else $error("interrupt without unmasked status");

    COV_SWB: cover property (cfg.sw_break && event_hit);
    COV_NEG_RANGE: cover property (cfg.negate && cfg.addr_mode == BEC_AM_RANGE && event_hit);
    COV_MASKED: cover property (cfg.data_en && cfg.mask_en && event_hit);
    COV_IRQ: cover property (!irq ##1 irq);
endmodule : bec_top

// file: tb/bec_bus_model.sv
// Behavioural target CPU that presents monitored bus cycles
`timescale 1ns/1ns
module bec_bus_model
#(
    parameter int AW = 24,
    parameter int DW = 16
)
(
    // Clock
    input  wire logic          clock,
    // Monitored cycle
    output logic               mon_valid,
    output logic [AW-1:0]      mon_addr,
    output logic [DW-1:0]      mon_data,
    output logic               mon_word,
    output logic               mon_write,
    output logic               mon_fetch,
    output logic [2:0]         mon_state,
    output logic [2:0]         mon_area
);
    // Quiet bus at time zero
    initial
    begin
        mon_valid = 1'b0;
        mon_addr  = '0;
        mon_data  = '0;
        {mon_word, mon_write, mon_fetch, mon_state, mon_area} = 9'h000;
    end

    // One cycle; f = {word, write, fetch, state, area}
    task automatic cycle(input logic [AW-1:0] a, input logic [DW-1:0] d,
                         input logic [8:0] f);
        @(posedge clock);
        mon_valid <= 1'b1;
        mon_addr  <= a;
        mon_data  <= d;
        {mon_word, mon_write, mon_fetch, mon_state, mon_area} <= f;
        @(posedge clock);
        // Inverted leftovers so a stale field never matches by luck
        mon_valid <= 1'b0;
        mon_addr  <= ~a;
        mon_data  <= ~d;
        {mon_word, mon_write, mon_fetch, mon_state, mon_area} <= ~f;
    endtask : cycle
endmodule : bec_bus_model

// file: tb/bec_top_tb.sv
// Self-checking bench of the bus event comparator
`timescale 1ns/1ns
`include "bec_params.svh"
module bec_top_tb
    import bec_pkg::*;
();
    logic        clock       = 1'b0;
    logic        reset       = 1'b1;
    logic        cyc         = 1'b0;
    logic        stb         = 1'b0;
    logic        we          = 1'b0;
    logic [7:0]  adr         = 8'h00;
    logic [3:0]  sel         = 4'h0;
    logic [31:0] wdat        = 32'h0000_0000;
    logic [31:0] rdat;
    logic [31:0] dat_o;
    logic        ack, hit, irq, mv, mw, mwr, mf;
    logic [23:0] ma;
    logic [15:0] md;
    logic [2:0]  ms, mar;
    int          fails       = 0;
    int          checks_done = 0;

    // 25 MHz clock
    always #20 clock = ~clock;

    bec_top i_bec_top (.clock(clock), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .mon_valid(mv), .mon_addr(ma), .mon_data(md), .mon_word(mw),
        .mon_write(mwr), .mon_fetch(mf), .mon_state(ms), .mon_area(mar),
        .event_hit(hit), .irq(irq));

    bec_bus_model i_bec_bus_model (.clock(clock), .mon_valid(mv), .mon_addr(ma),
        .mon_data(md), .mon_word(mw), .mon_write(mwr), .mon_fetch(mf), .mon_state(ms),
        .mon_area(mar));

    // Verdict and end of run
    task automatic complete_run;
        if (fails == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : complete_run

    // Compare and tally
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Classic Wishbone cycle; read data taken only at the ack edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        sel  <= 4'hF;
        wdat <= d;
        do
            @(posedge clock);
        while (ack !== 1'b1);
        rdat = dat_o;
        cyc  <= 1'b0;
        stb  <= 1'b0;
        we   <= 1'b0;
    endtask : wb

    // One monitored cycle, hit judged in the following cycle
    task automatic probe(input logic [23:0] a, input logic [15:0] d, input logic [8:0] f,
                         input logic e);
        i_bec_bus_model.cycle(a, d, f);
        #1 chk({31'd0, hit}, {31'd0, e});
    endtask : probe

    // Reset values and an unmapped offset
    task automatic t_reset;
        wb(1'b0, `BEC_OFF_CTRL, 32'h0);
        chk(rdat, 32'h0000_0E00);
        wb(1'b0, `BEC_OFF_SSEL, 32'h0);
        chk(rdat, 32'h0000_00FF);
        wb(1'b0, `BEC_OFF_ASEL, 32'h0);
        chk(rdat, 32'h0000_00FF);
        wb(1'b1, 8'h40, 32'hFFFF_FFFF);
        wb(1'b0, 8'h40, 32'h0);
        chk(rdat, 32'h0000_0000);
    endtask : t_reset

    // Fetch break with the data and direction conditions set against it
    task automatic t_swbreak;
        wb(1'b1, `BEC_OFF_ADDR_LO, 32'h0000_1234);
        wb(1'b1, `BEC_OFF_CTRL, 32'h0000_01A3);
        probe(24'h00_1234, 16'h5555, 9'h140, 1'b1);
        probe(24'h00_1235, 16'h5555, 9'h140, 1'b0);
        probe(24'h00_1234, 16'h5555, 9'h100, 1'b0);
    endtask : t_swbreak

    // Ignore, single, range and both negated forms at window edges
    task automatic t_addr;
        logic [31:0] mode [5] = '{32'h0000_0E01, 32'h0000_0E05, 32'h0000_0E09,
                                  32'h0000_0E15, 32'h0000_0E19};
        logic [4:0]  expv [5] = '{5'b11111, 5'b00010, 5'b01110, 5'b11101, 5'b10001};
        logic [23:0] adv  [5] = '{24'h00_00FF, 24'h00_0100, 24'h00_0150,
                                  24'h00_01FF, 24'h00_0200};
        wb(1'b1, `BEC_OFF_ADDR_LO, 32'h0000_0100);
        wb(1'b1, `BEC_OFF_ADDR_HI, 32'h0000_01FF);
        for (int m = 0; m < 5; m++)
        begin
            wb(1'b1, `BEC_OFF_CTRL, mode[m]);
            for (int j = 0; j < 5; j++)
                probe(adv[j], 16'h0000, 9'h100, expv[m][j]);
        end
    endtask : t_addr

    // Data value, mask and size
    task automatic t_data;
        logic [31:0] ctl [8] = '{32'h0000_0EA1, 32'h0000_0EA1, 32'h0000_0EA1, 32'h0000_0E21,
                                 32'h0000_0E21, 32'h0000_0EE1, 32'h0000_0EE1, 32'h0000_0E01};
        logic [15:0] dv  [8] = '{16'h12A5, 16'h12A4, 16'h12A5, 16'hFFA5,
                                 16'hFFA5, 16'h3275, 16'h3375, 16'h3375};
        logic [8:0]  fl  [8] = '{9'h100, 9'h100, 9'h000, 9'h000,
                                 9'h100, 9'h100, 9'h100, 9'h000};
        logic [7:0]  ex      = 8'b1001_0101;
        wb(1'b1, `BEC_OFF_DVAL, 32'h0000_12A5);
        wb(1'b1, `BEC_OFF_DMASK, 32'h0000_0F0F);
        for (int i = 0; i < 8; i++)
        begin
            wb(1'b1, `BEC_OFF_CTRL, ctl[i]);
            probe(24'h00_0000, dv[i], fl[i], ex[7-i]);
        end
    endtask : t_data

    // Read, write, either and the code that never matches
    task automatic t_dir;
        for (int d = 0; d < 4; d++)
        begin
            wb(1'b1, `BEC_OFF_CTRL, 32'h0000_0C01 | (d << 8));
            probe(24'h0, 16'h0, 9'h100, d == BEC_DIR_READ || d == BEC_DIR_EITHER);
            probe(24'h0, 16'h0, 9'h180, d == BEC_DIR_WRITE || d == BEC_DIR_EITHER);
        end
    endtask : t_dir

    // Bus state, area, address with direction, state and area together, disabled block
    task automatic t_area;
        wb(1'b1, `BEC_OFF_SSEL, 32'h0000_0004);
        wb(1'b1, `BEC_OFF_ASEL, 32'h0000_0020);
        wb(1'b1, `BEC_OFF_CTRL, 32'h0000_0201);
        probe(24'h0, 16'h0, 9'h115, 1'b1);
        probe(24'h0, 16'h0, 9'h11D, 1'b0);
        probe(24'h0, 16'h0, 9'h114, 1'b0);
        wb(1'b1, `BEC_OFF_CTRL, 32'h0000_0E01);
        probe(24'h0, 16'h0, 9'h11C, 1'b1);
        wb(1'b1, `BEC_OFF_ADDR_LO, 32'h0000_0ABC);
        wb(1'b1, `BEC_OFF_CTRL, 32'h0000_0105);
        probe(24'h00_0ABC, 16'h0, 9'h195, 1'b1);
        probe(24'h00_0ABC, 16'h0, 9'h115, 1'b0);
        probe(24'h00_0ABD, 16'h0, 9'h195, 1'b0);
        wb(1'b1, `BEC_OFF_CTRL, 32'h0000_0E00);
        probe(24'h0, 16'h0, 9'h100, 1'b0);
    endtask : t_area

    // Sticky status, mask and level interrupt
    task automatic t_irq;
        wb(1'b1, `BEC_OFF_ISTS, 32'h0000_0001);
        wb(1'b1, `BEC_OFF_IMSK, 32'h0000_0001);
        chk({31'd0, irq}, 32'h0);
        wb(1'b1, `BEC_OFF_CTRL, 32'h0000_0E01);
        probe(24'h00_0777, 16'h0, 9'h100, 1'b1);
        chk({31'd0, irq}, 32'h1);
        wb(1'b0, `BEC_OFF_HADDR, 32'h0);
        chk(rdat, 32'h0000_0777);
        wb(1'b1, `BEC_OFF_IMSK, 32'h0000_0000);
        chk({31'd0, irq}, 32'h0);
        wb(1'b0, `BEC_OFF_ISTS, 32'h0);
        chk(rdat, 32'h0000_0001);
        wb(1'b1, `BEC_OFF_ISTS, 32'h0000_0001);
        wb(1'b0, `BEC_OFF_ISTS, 32'h0);
        chk(rdat, 32'h0000_0000);
        wb(1'b1, `BEC_OFF_IMSK, 32'h0000_0001);
        chk({31'd0, irq}, 32'h0);
        // Every expected hit of the whole run, counted by hand
        wb(1'b0, `BEC_OFF_HCNT, 32'h0);
        chk(rdat, 32'h0000_001C);
    endtask : t_irq

    // Watchdog, far beyond the few hundred cycles the run needs
    initial
    begin
        repeat (5000) @(posedge clock);
        fails++;
        complete_run();
    end

    // Main sequence
    initial
    begin
        repeat (8) @(posedge clock);
        reset <= 1'b0;
        t_reset();
        t_swbreak();
        t_addr();
        t_data();
        t_dir();
        t_area();
        t_irq();
        complete_run();
    end
endmodule : bec_top_tb
